// File: rtl/agcgc_consts.vh
// constants for the step-wise audio gain controller
`ifndef AGCGC_CONSTS_VH
`define AGCGC_CONSTS_VH

// mode-select decode {mode_select_high, mode_select_low}
`define AGCGC_MODE_OFF 2'b00
`define AGCGC_MODE_LIM 2'b01
`define AGCGC_MODE_CMP 2'b10
`define AGCGC_MODE_GATE 2'b11

// gain code counts 0.5 dB steps, code 0 = 0 dB
`define AGCGC_GAIN_W 6
`define AGCGC_GAIN_MAX 6'h3c
`define AGCGC_GAIN_FIXED 6'h12
`define AGCGC_STEPS_PER_6DB 12

// envelope and threshold levels, linear codes
`define AGCGC_ENV_W 16
`define AGCGC_LIMIT_LVL 16'h4000
`define AGCGC_GATE_LVL 16'h0040
`define AGCGC_NEAR_BAND 16'h0100
`define AGCGC_ENV_SHIFT 4

// timing figures in microseconds and the clock period in ns
`define AGCGC_CLK_NS 10
`define AGCGC_ATTACK_US 14084
`define AGCGC_RELEASE_US 822000
`define AGCGC_HOLD_US 0

// thermal trip level in degrees C
`define AGCGC_TEMP_W 8
`define AGCGC_TEMP_TRIP 8'h96

`endif

// File: rtl/agcgc_top.v
// step-wise automatic gain controller for a mono amplifier
// Summary of operation
// RL1 - gain decisions follow detected envelope, not samples
// RL2 - every adjustment moves gain one 0.5 dB step
// RL3 - near-constant envelope blocks gain raises
// RL4 - first overshoot cuts one step, restarts timers
// RL5 - no gain change while attack runs
// RL6 - attack expiry, still above limit: cut again
// RL7 - release expiry below target: raise one step
// RL8 - static mode pins: off, limit, compress, gate
// RL9 - target from envelope, limit, ratio, max gain; target here uses envelope, limit, ratio only
// RL10 - attack 14.084 ms, release 822 ms per 6 dB
// RL11 - gain saturates at its range limits
// RL12 - all parameters fixed constants, no registers
// RL13 - thermal trip above 150 C shuts off
// RL14 - noise gate stops gain rising in quiet
`timescale 1ns/10ps
`include "agcgc_consts.vh"

module agcgc_top #(
    parameter [31:0] ATTACK_CYC = (`AGCGC_ATTACK_US * 1000 / `AGCGC_CLK_NS)
        / `AGCGC_STEPS_PER_6DB,
    parameter [31:0] RELEASE_CYC = (`AGCGC_RELEASE_US * 1000 / `AGCGC_CLK_NS)
        / `AGCGC_STEPS_PER_6DB
) (
    input wire clk_sys, // system clock, 100 MHz
    input wire nrst, // async reset, active low
    input wire clk_en, // freezes all state but the reset release flops while low
    input wire [15:0] sample_mag, // input sample magnitude, same clock
    input wire sample_vld, // sample_mag holds a new value
    input wire mode_select_high, // mode pin from host, asynchronous
    input wire mode_select_low, // mode pin from host, asynchronous
    input wire [7:0] die_temp, // junction temperature, degrees C
    output reg [5:0] gain_code_r, // applied gain, 0.5 dB per code
    output reg gain_step_r, // pulse: gain moved one step
    output reg gain_dir_r, // 1 = last step was up
    output reg [1:0] mode_r, // decoded mode in force
    output reg limit_active_r, // envelope above limiter level
    output reg gate_active_r, // noise gate holding gain
    output reg amp_on_r // amplifier enabled, low on thermal trip
);

    ////////////////////////////////////////////////////////////////
    // reset release and constants

    // derived cycle counts, each at least one cycle
    localparam [31:0] ATT_N = (ATTACK_CYC == 0) ? 32'h1 : ATTACK_CYC; // [RL10]
    localparam [31:0] REL_N = (RELEASE_CYC == 0) ? 32'h1 : RELEASE_CYC; // [RL10]
    localparam [5:0] GMAX = `AGCGC_GAIN_MAX;
    localparam [15:0] LIMIT = `AGCGC_LIMIT_LVL;
    localparam [15:0] GATE = `AGCGC_GATE_LVL;
    localparam [15:0] BAND = `AGCGC_NEAR_BAND;

    reg rst_a_r;
    reg rst_b_r;
    wire rst_n = rst_b_r;

    // two-flop release so every flop leaves reset on one edge
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            rst_a_r <= 1'b0;
            rst_b_r <= 1'b0;
        end else begin
            rst_a_r <= 1'b1;
            rst_b_r <= rst_a_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // mode pin synchronisers

    reg [1:0] ms1_r;
    reg [1:0] ms2_r;
    reg [1:0] ms3_r;

    // three stages; a change counts only when stage two and three agree
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ms1_r <= 2'h0;
            ms2_r <= 2'h0;
            ms3_r <= 2'h0;
        end else if (clk_en) begin
            ms1_r <= {mode_select_high, mode_select_low};
            ms2_r <= ms1_r;
            ms3_r <= ms2_r;
        end
    end

    ////////////////////////////////////////////////////////////////
    // envelope detector

    reg [15:0] env_r;
    reg [15:0] env_nxt;
    reg [15:0] env_prev_r;

    // peak follower: instant rise, slow exponential decay
    always @* begin
        env_nxt = env_r;
        if (sample_vld) begin
            if (sample_mag > env_r)
                env_nxt = sample_mag; // [RL1]
            else
                env_nxt = env_r - (env_r >> `AGCGC_ENV_SHIFT); // [RL1]
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            env_r <= 16'h0;
        end else if (clk_en) begin
            env_r <= env_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////
    // target computation

    // absolute difference, used for the stability band and target
    function [15:0] absdiff;
        input [15:0] a;
        input [15:0] b;
        begin
            absdiff = (a > b) ? (a - b) : (b - a);
        end
    endfunction

    // compression is in force in both the compress and gate modes
    function cmp_mode;
        input [1:0] m;
        begin
            cmp_mode = (m == `AGCGC_MODE_CMP) || (m == `AGCGC_MODE_GATE);
        end
    endfunction

    // the noise gate exists only in the top mode code
    function gate_mode;
        input [1:0] m;
        begin
            gate_mode = (m == `AGCGC_MODE_GATE);
        end
    endfunction

    // 2:1 ratio: the target moves half way from the limit toward env
    function [15:0] cmp_target;
        input [15:0] env;
        begin
            cmp_target = LIMIT - (absdiff(LIMIT, env) >> 1);
        end
    endfunction

    reg [15:0] tgt_lvl;
    wire above_lim = (env_r > LIMIT);
    wire gate_on = gate_mode(mode_r) && (env_r < GATE);
    wire settled = (absdiff(env_r, env_prev_r) < BAND);

    // target below which gain rises; compression halves the distance,
    // so quiet passages are lifted by less than the full gap
    always @* begin
        tgt_lvl = LIMIT;
        if (cmp_mode(mode_r))
            tgt_lvl = cmp_target(env_r); // [RL9]
    end

    wire below_tgt = (env_r < tgt_lvl) && !above_lim;
    wire want_up = below_tgt && !gate_on && !settled; // [RL3] [RL14]

    ////////////////////////////////////////////////////////////////
    // mode and step helpers

    // agc runs in every mode but the all-zero code
    function agc_mode;
        input [1:0] m;
        begin
            agc_mode = (m != `AGCGC_MODE_OFF); // [RL8]
        end
    endfunction

    // one 0.5 dB step either way; callers keep the code inside its range
    function [5:0] step_gain;
        input [5:0] g;
        input up;
        begin
            step_gain = up ? (g + 6'h1) : (g - 6'h1); // [RL2]
        end
    endfunction

    ////////////////////////////////////////////////////////////////
    // step decision

    reg [31:0] att_cnt_r;
    reg [31:0] rel_cnt_r;
    wire att_busy = (att_cnt_r != 32'h0);
    wire rel_done = (rel_cnt_r == 32'h1);
    wire agc_on = agc_mode(mode_r);
    wire at_floor = (gain_code_r == 6'h0);
    wire at_ceiling = (gain_code_r == GMAX);
    reg do_down;
    reg do_up;
    wire do_step = do_down | do_up;

    // attack only starts a cut when idle, and blocks while running;
    // a cut outranks a raise so an overload is never made worse
    always @* begin
        do_down = 1'b0;
        do_up = 1'b0;
        if (agc_on && amp_on_r) begin
            if (above_lim && !att_busy && !at_floor)
                do_down = 1'b1; // [RL4] [RL5] [RL6] [RL11]
            else if (!above_lim && rel_done && want_up && !at_ceiling)
                do_up = 1'b1; // [RL7] [RL11]
        end
    end

    ////////////////////////////////////////////////////////////////
    // status flags

    // mode only moves once two sync stages agree, so a pin edge that
    // lands near the clock cannot show a half-changed code
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mode_r <= 2'h0;
            amp_on_r <= 1'b0;
            limit_active_r <= 1'b0;
            gate_active_r <= 1'b0;
        end else if (clk_en) begin
            if (ms2_r == ms3_r)
                mode_r <= ms3_r; // [RL8]
            amp_on_r <= (die_temp <= `AGCGC_TEMP_TRIP); // [RL13]
            limit_active_r <= above_lim;
            gate_active_r <= gate_on;
        end
    end

    ////////////////////////////////////////////////////////////////
    // applied gain

    // agc off forces the fixed gain; a shutdown freezes the code
    // rather than resetting it, so recovery resumes where it was
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            gain_code_r <= `AGCGC_GAIN_FIXED;
            gain_step_r <= 1'b0;
            gain_dir_r <= 1'b0;
        end else if (clk_en) begin
            gain_step_r <= do_step;
            if (!agc_on) begin
                gain_code_r <= `AGCGC_GAIN_FIXED; // [RL8] [RL12]
            end else if (do_step) begin
                gain_code_r <= step_gain(gain_code_r, do_up); // [RL2]
                gain_dir_r <= do_up;
            end
        end
    end

    ////////////////////////////////////////////////////////////////
    // attack timer

    // loaded by any step, then counts down to idle; hold is off so
    // no separate hold count is kept
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            att_cnt_r <= 32'h0;
        end else if (clk_en) begin
            if (!agc_on)
                att_cnt_r <= 32'h0;
            else if (do_step)
                att_cnt_r <= ATT_N; // [RL4] [RL6] [RL7]
            else if (att_busy)
                att_cnt_r <= att_cnt_r - 32'h1; // [RL5]
        end
    end

    ////////////////////////////////////////////////////////////////
    // release timer

    // free running: reloads on a step and on its own expiry, so raises
    // repeat once per release interval while the envelope stays low and keeps moving
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rel_cnt_r <= 32'h0;
        end else if (clk_en) begin
            if (!agc_on || do_step || rel_done)
                rel_cnt_r <= REL_N; // [RL7]
            else if (rel_cnt_r > 32'h1)
                rel_cnt_r <= rel_cnt_r - 32'h1;
        end
    end

    ////////////////////////////////////////////////////////////////
    // stability reference

    // envelope is compared with its value at the last step or release
    // end; re-arming each interval keeps a slow drift from counting as change
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            env_prev_r <= 16'h0;
        end else if (clk_en && agc_on && (do_step || rel_done)) begin
            env_prev_r <= env_r; // [RL3]
        end
    end

endmodule // agcgc_top

// File: dv/agcgc_chk.sv
// assertions on the gain controller ports
`timescale 1ns/10ps
module agcgc_chk #(parameter [31:0] ATTACK_CYC = 8, parameter [31:0] RELEASE_CYC = 32) (
    input wire clk_sys, // clock
    input wire nrst, // reset
    input wire clk_en, // enable
    input wire [7:0] die_temp, // temp
    input wire [5:0] gain_code_r, // gain
    input wire gain_step_r, // step
    input wire gain_dir_r, // up
    input wire [1:0] mode_r, // mode
    input wire gate_active_r, // gate
    input wire amp_on_r // amp on
);
    reg [31:0] since_r; // cycles since step
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!nrst);
    // saturates, so a long quiet spell never wraps
    always @(posedge clk_sys or negedge nrst) begin
        if (!nrst) since_r <= 32'hffffffff;
        else if (gain_step_r) since_r <= 32'h1;
        else if (~&since_r) since_r <= since_r + 32'h1;
    end
    sequence s_hot;
        (die_temp > 8'h96 && clk_en) [*2];
    endsequence
    sequence s_off;
        (mode_r == 2'h0) [*3];
    endsequence
    a_step_size: assert property (gain_step_r |-> gain_code_r ==
        (gain_dir_r ? $past(gain_code_r) + 6'h1 : $past(gain_code_r) - 6'h1))
        else $error("step not one code");
    a_gain_hold: assert property (!gain_step_r && |mode_r && |$past(mode_r) |->
        $stable(gain_code_r)) else $error("gain moved without step");
    a_attack_gap: assert property (gain_step_r |-> since_r >= ATTACK_CYC)
        else $error("step inside attack");
    a_release_gap: assert property (gain_step_r && gain_dir_r |-> since_r >= RELEASE_CYC)
        else $error("raise before release end");
    a_off_fixed: assert property (s_off |-> gain_code_r == 6'h12 && !gain_step_r)
        else $error("gain not fixed when off");
    a_gain_range: assert property (gain_code_r <= 6'h3c)
        else $error("gain above range");
    a_thermal_off: assert property (s_hot |-> !amp_on_r)
        else $error("amp on while hot");
    a_hot_frozen: assert property (!amp_on_r |=> !gain_step_r)
        else $error("step while shut off");
    a_gate_hold: assert property (gate_active_r && $past(gate_active_r) && gain_step_r |->
        !gain_dir_r) else $error("raise while gated");
endmodule // agcgc_chk
bind agcgc_top agcgc_chk #(.ATTACK_CYC(ATTACK_CYC), .RELEASE_CYC(RELEASE_CYC)) u_chk (.*);

// File: dv/agcgc_host.sv
// host model driving the mode pins
`timescale 1ns/10ps
module agcgc_host (
    input wire clk_sys, // clock
    input wire [1:0] mode_req, // mode wanted
    output reg mode_select_high = 1'b0, // pin
    output reg mode_select_low = 1'b0 // pin
);
    // pins move only on request, else static
    always @(posedge clk_sys) {mode_select_high, mode_select_low} <= mode_req;
endmodule // agcgc_host

// File: dv/agcgc_top_bench.sv
// self-checking bench for the gain controller
`timescale 1ns/10ps
module agcgc_top_bench;
    reg clk_sys = 1'b0;
    reg nrst = 1'b0;
    reg sample_vld = 1'b0;
    reg saw = 1'b0;
    reg [15:0] sample_mag = 16'h0000;
    reg [7:0] die_temp = 8'h19;
    reg [1:0] mode_req = 2'h0;
    reg clk_en = 1'b1;
    reg [5:0] p;
    wire mode_select_high, mode_select_low, gain_step_r, gain_dir_r;
    wire limit_active_r, gate_active_r, amp_on_r;
    wire [5:0] gain_code_r;
    wire [1:0] mode_r;
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    initial forever #5 clk_sys = ~clk_sys;
    // ramp wraps below the limiter, keeps the envelope moving
    always @(posedge clk_sys) if (saw) sample_mag <= sample_mag + 16'h0100 & 16'h3fff;
    agcgc_host u_host (.*);
    agcgc_top #(.ATTACK_CYC(8), .RELEASE_CYC(32)) u_dut (.*);
    task automatic chk(input bit ok, input string m);
        samples_checked++;
        if (!ok) begin
            error_cnt++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // bounded wait for a step, p keeps the code before it
    task automatic wait_step(input int lim);
        n = 0;
        do begin
            p = gain_code_r;
            @(negedge clk_sys) n++;
            if (n > lim) chk(1'b0, "no step");
            if (n > lim) finish_test();
        end while (gain_step_r !== 1'b1);
    endtask
    task automatic t_down();
        @(posedge clk_sys) mode_req <= 2'h1;
        sample_mag <= 16'h5000;
        sample_vld <= 1'b1;
        wait_step(20);
        chk(gain_dir_r === 1'b0 && gain_code_r === p - 6'h1, "cut");
        wait_step(20);
        chk(n >= 8 && gain_dir_r === 1'b0 && limit_active_r === 1'b1, "cut2");
    endtask
    task automatic t_up();
        @(posedge clk_sys) saw <= 1'b1;
        repeat (40) @(negedge clk_sys);
        wait_step(200);
        chk(gain_dir_r === 1'b1 && gain_code_r === p + 6'h1, "raise");
    endtask
    task automatic t_gate();
        @(posedge clk_sys) saw <= 1'b0;
        @(posedge clk_sys) mode_req <= 2'h3;
        sample_mag <= 16'h0010;
        repeat (150) @(negedge clk_sys);
        p = gain_code_r;
        repeat (100) @(negedge clk_sys);
        chk(gate_active_r === 1'b1 && gain_code_r === p, "gate");
    endtask
    task automatic t_therm();
        @(posedge clk_sys) die_temp <= 8'h96;
        repeat (4) @(negedge clk_sys);
        chk(amp_on_r === 1'b1, "on at trip");
        @(posedge clk_sys) clk_en <= 1'b0;
        die_temp <= 8'h97;
        repeat (4) @(negedge clk_sys);
        chk(amp_on_r === 1'b1, "moved while frozen");
        @(posedge clk_sys) clk_en <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(amp_on_r === 1'b0, "on above trip");
    endtask
    task automatic t_modes();
        for (int m = 3; m >= 0; m--) begin
            @(posedge clk_sys) mode_req <= m[1:0];
            repeat (8) @(negedge clk_sys);
            chk(mode_r === m[1:0], "mode");
        end
        chk(gain_code_r === 6'h12, "fixed gain");
    endtask
    initial begin
        repeat (12) @(posedge clk_sys);
        nrst <= 1'b1;
        repeat (4) @(negedge clk_sys);
        chk(gain_code_r === 6'h12 && amp_on_r === 1'b1, "reset");
        t_down();
        t_up();
        t_gate();
        t_therm();
        t_modes();
        finish_test();
    end
endmodule // agcgc_top_bench
